// ---- rtl/cio_pkg.sv ----
package cio_pkg;

  // structure of the port array
  localparam int CIO_NPORT = 5;
  localparam int CIO_NCLK  = 6;
  localparam int CIO_NPIN  = 32;
  localparam int CIO_CNT_W = 16;
  localparam int CIO_AW    = 12;

  // per-port register window: port p at byte address p * 0x20
  localparam logic [11:0] CIO_PORT_END   = 12'h0A0;
  localparam logic [4:0]  CIO_OFF_CTRL   = 5'h00;
  localparam logic [4:0]  CIO_OFF_DATA   = 5'h04;
  localparam logic [4:0]  CIO_OFF_TIME   = 5'h08;
  localparam logic [4:0]  CIO_OFF_TSTAMP = 5'h0C;
  localparam logic [4:0]  CIO_OFF_COND   = 5'h10;
  localparam logic [4:0]  CIO_OFF_STAT   = 5'h14;

  // global registers
  localparam logic [11:0] CIO_OFF_LINK     = 12'h100;
  localparam logic [11:0] CIO_OFF_CLKDIV   = 12'h140;
  localparam logic [11:0] CIO_OFF_IRQ_STAT = 12'h180;
  localparam logic [11:0] CIO_OFF_IRQ_MASK = 12'h184;

  // pins that the inter-chip link takes over when enabled
  localparam logic [31:0] CIO_LINK_PIN_MASK = 32'h000000F0;
  // pin that may serve as an external clock source
  localparam int          CIO_CLK_PIN       = 0;

  // values after reset
  localparam logic [15:0] CIO_DIV_RST     = 16'h0000;
  localparam logic [2:0]  CIO_CLK_SEL_RST = 3'h0;
  localparam logic [15:0] CIO_CNT_RST     = 16'h0000;

  typedef enum logic [1:0] {
    CIO_COND_NONE,
    CIO_COND_EQ,
    CIO_COND_NE
  } cio_cond_type;

  typedef enum logic {
    CIO_EMPTY,
    CIO_FULL
  } cio_xfer_type;

  // port control word, bit 0 = enable
  typedef struct packed {
    logic [2:0]   clk_sel;
    logic         strb_out;
    logic         strb_in;
    cio_cond_type cond;
    logic         time_wait;
    logic         open_drain;
    logic         dir_out;
    logic         enable;
  } cio_cfg_type;

  typedef struct packed {
    logic        full;
    logic [15:0] count;
    logic [15:0] tstamp;
  } cio_stat_type;

  localparam cio_cfg_type CIO_CFG_RST = cio_cfg_type'({3'h0, 8'h00});

  function automatic int cio_port_width(input int p);
    case (p)
      0:       return 1;
      1:       return 4;
      2:       return 8;
      3:       return 16;
      default: return 32;
    endcase
  endfunction

  function automatic logic [31:0] cio_be_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ---- rtl/cio_port_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - ports of width 1, 4, 8, 16 and 32 on fixed pin groups.
// - all pins of one port share one direction at any time.
// - port drives pins or samples them, optionally waiting for a condition.
// - every software write to a port completes within one cycle; reads take one wait cycle.
// - open-drain port drives low for zero and releases for one.
// - data moves through a serdes register plus a transfer register.
// - a 16-bit counter per port times pin transfers.
// - counter readable anytime; a programmed future value delays transfer.
// - each transfer captures the counter as a timestamp.
// - enabled inter-chip link disables ports on its shared pins.
// - an enabled narrower port overrides wider ports on shared pins.
// - unshared pins of a wider port remain usable by it.
// - a port always moves words of its nominal width.
// - six clock blocks; block 0 is reference, others programmable.
// - clock block may use an external 1-bit pin, optionally divided.
// - ports honour incoming ready strobe and may emit outgoing strobe.
// - after reset every port uses clock block 0.
// - pin-condition events go straight to the scheduler.
module cio_port_top
  import cio_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // avalon-mm slave
  input  wire logic [11:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // pins
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe_b_out,
  // ready strobes, one per port
  input  wire logic [4:0]  strobe_in_handshake_in,
  output logic      [4:0]  strobe_out_handshake_out,
  // scheduler events and interrupt
  output logic      [4:0]  event_out,
  output logic             irq_out
);

  // register bank state
  cio_cfg_type  cfg_q [CIO_NPORT];
  cio_cfg_type  cfg_d [CIO_NPORT];
  logic         link_q, link_d;
  logic [15:0]  div_q [CIO_NCLK];
  logic [15:0]  div_d [CIO_NCLK];
  logic         ext_q [CIO_NCLK];
  logic         ext_d [CIO_NCLK];
  logic [4:0]   ist_q, ist_d;
  logic [4:0]   imask_q, imask_d;
  logic         irq_q, irq_d;
  logic         rd_done_q, rd_done_d;
  logic [31:0]  rdata_q, rdata_d;

  // clock block state
  logic [15:0]  cb_cnt_q [CIO_NCLK];
  logic [15:0]  cb_cnt_d [CIO_NCLK];
  logic [5:0]   cb_tick;
  logic         clk_pin_q;

  // synchronisers for pins and strobes
  logic [31:0]  pin_s1_q, pin_s2_q;
  logic [4:0]   stb_s1_q, stb_s2_q;

  // pin multiplexer
  logic [31:0]  pout_q, pout_d;
  logic [31:0]  poe_b_q, poe_b_d;
  logic [2:0]   owner [CIO_NPIN];
  logic [31:0]  port_pin_in [CIO_NPORT];
  logic [31:0]  port_pin_out [CIO_NPORT];

  // per-port views for the bus
  logic [31:0]  port_xfer [CIO_NPORT];
  logic [31:0]  port_cond [CIO_NPORT];
  cio_stat_type port_stat [CIO_NPORT];
  logic [4:0]   port_evt;
  logic [4:0]   port_stb;
  logic [4:0]   port_tick;

  // bus decode
  logic         in_ports;
  logic [2:0]   sel_port;
  logic [4:0]   sel_off;
  logic         wr_acc;
  logic         rd_acc;
  logic [31:0]  wmerged;
  logic [31:0]  ctl_merged;
  logic [4:0]   wr_data, wr_time, wr_cond, rd_pop;

  // owner of a pin: lowest enabled port covering it, 5 means nobody
  function automatic logic [2:0] pin_owner(input int         pin,
                                           input logic [4:0] en,
                                           input logic       link);
    logic [2:0] r;
    r = 3'h5;
    for (int p = CIO_NPORT - 1; p >= 0; p--) begin
      if (en[p] && pin < cio_port_width(p)) begin
        r = 3'(p);
      end
    end
    if (link && CIO_LINK_PIN_MASK[pin]) begin
      r = 3'h5;
    end
    return r;
  endfunction

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pin_s1_q  <= 32'h00000000;
      pin_s2_q  <= 32'h00000000;
      stb_s1_q  <= 5'h00;
      stb_s2_q  <= 5'h00;
      clk_pin_q <= 1'b0;
    end else begin
      pin_s1_q  <= pin_in;
      pin_s2_q  <= pin_s1_q;
      stb_s1_q  <= strobe_in_handshake_in;
      stb_s2_q  <= stb_s1_q;
      clk_pin_q <= pin_s2_q[CIO_CLK_PIN];
    end
  end

  // clock blocks: block 0 ticks every reference cycle
  always_comb begin
    cb_tick     = 6'h00;
    cb_tick[0]  = 1'b1;
    cb_cnt_d[0] = CIO_CNT_RST;
    for (int k = 1; k < CIO_NCLK; k++) begin
      cb_cnt_d[k] = cb_cnt_q[k];
      if (!ext_q[k] || (pin_s2_q[CIO_CLK_PIN] && !clk_pin_q)) begin
        if (cb_cnt_q[k] >= div_q[k]) begin
          cb_cnt_d[k] = CIO_CNT_RST;
          cb_tick[k]  = 1'b1;
        end else begin
          cb_cnt_d[k] = cb_cnt_q[k] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      for (int k = 0; k < CIO_NCLK; k++) begin
        cb_cnt_q[k] <= CIO_CNT_RST;
      end
    end else begin
      for (int k = 0; k < CIO_NCLK; k++) begin
        cb_cnt_q[k] <= cb_cnt_d[k];
      end
    end
  end

  // bus decode; writes finish at once, reads take one wait cycle
  always_comb begin
    in_ports = avs_address_in < CIO_PORT_END;
    sel_port = avs_address_in[7:5];
    sel_off  = avs_address_in[4:0];
    wr_acc   = avs_write_in;
    rd_acc   = avs_read_in && !rd_done_q;
    wmerged  = cio_be_merge(32'h00000000, avs_writedata_in,
                            avs_byteenable_in);
    for (int p = 0; p < CIO_NPORT; p++) begin
      wr_data[p] = wr_acc && in_ports && sel_port == 3'(p) &&
                   sel_off == CIO_OFF_DATA;
      wr_time[p] = wr_acc && in_ports && sel_port == 3'(p) &&
                   sel_off == CIO_OFF_TIME;
      wr_cond[p] = wr_acc && in_ports && sel_port == 3'(p) &&
                   sel_off == CIO_OFF_COND;
      // reading input data empties the transfer register
      rd_pop[p]  = rd_acc && in_ports && sel_port == 3'(p) &&
                   sel_off == CIO_OFF_DATA;
    end
  end

  // register bank next values
  always_comb begin
    link_d    = link_q;
    ist_d     = ist_q;
    imask_d   = imask_q;
    rd_done_d = rd_acc;
    rdata_d   = rdata_q;
    ctl_merged = 32'h00000000;
    for (int p = 0; p < CIO_NPORT; p++) begin
      cfg_d[p] = cfg_q[p];
      if (wr_acc && in_ports && sel_port == 3'(p) &&
          sel_off == CIO_OFF_CTRL) begin
        ctl_merged = cio_be_merge(32'(cfg_q[p]), avs_writedata_in,
                                  avs_byteenable_in);
        cfg_d[p]   = cio_cfg_type'(ctl_merged[10:0]);
      end
    end
    for (int k = 0; k < CIO_NCLK; k++) begin
      div_d[k] = div_q[k];
      ext_d[k] = ext_q[k];
      if (k > 0 && wr_acc && avs_address_in == CIO_OFF_CLKDIV + 12'(4*k))
      begin
        div_d[k] = wmerged[15:0];
        ext_d[k] = wmerged[16];
      end
    end
    if (wr_acc && avs_address_in == CIO_OFF_LINK) begin
      link_d = wmerged[0];
    end
    if (wr_acc && avs_address_in == CIO_OFF_IRQ_MASK) begin
      imask_d = wmerged[4:0];
    end
    // write-one-to-clear, a same-cycle event wins
    if (wr_acc && avs_address_in == CIO_OFF_IRQ_STAT) begin
      ist_d = ist_d & ~wmerged[4:0];
    end
    ist_d = ist_d | port_evt;
    irq_d = |(ist_q & imask_q);
    // read mux, unmapped addresses read as zero
    if (rd_acc) begin
      rdata_d = 32'h00000000;
      if (in_ports && sel_port < 3'h5) begin
        case (sel_off)
          CIO_OFF_CTRL:   rdata_d = 32'(cfg_q[sel_port]);
          CIO_OFF_DATA:   rdata_d = port_xfer[sel_port];
          CIO_OFF_TIME:   rdata_d = 32'(port_stat[sel_port].count);
          CIO_OFF_TSTAMP: rdata_d = 32'(port_stat[sel_port].tstamp);
          CIO_OFF_COND:   rdata_d = port_cond[sel_port];
          CIO_OFF_STAT:   rdata_d = 32'(port_stat[sel_port].full);
          default:        rdata_d = 32'h00000000;
        endcase
      end else if (avs_address_in == CIO_OFF_LINK) begin
        rdata_d = 32'(link_q);
      end else if (avs_address_in == CIO_OFF_IRQ_STAT) begin
        rdata_d = 32'(ist_q);
      end else if (avs_address_in == CIO_OFF_IRQ_MASK) begin
        rdata_d = 32'(imask_q);
      end else begin
        for (int k = 1; k < CIO_NCLK; k++) begin
          if (avs_address_in == CIO_OFF_CLKDIV + 12'(4*k)) begin
            rdata_d = {15'h0000, ext_q[k], div_q[k]};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      for (int p = 0; p < CIO_NPORT; p++) begin
        cfg_q[p] <= CIO_CFG_RST;
      end
      for (int k = 0; k < CIO_NCLK; k++) begin
        div_q[k] <= CIO_DIV_RST;
        ext_q[k] <= 1'b0;
      end
      link_q    <= 1'b0;
      ist_q     <= 5'h00;
      imask_q   <= 5'h00;
      irq_q     <= 1'b0;
      rd_done_q <= 1'b0;
      rdata_q   <= 32'h00000000;
    end else begin
      for (int p = 0; p < CIO_NPORT; p++) begin
        cfg_q[p] <= cfg_d[p];
      end
      for (int k = 0; k < CIO_NCLK; k++) begin
        div_q[k] <= div_d[k];
        ext_q[k] <= ext_d[k];
      end
      link_q    <= link_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      irq_q     <= irq_d;
      rd_done_q <= rd_done_d;
      rdata_q   <= rdata_d;
    end
  end

  // pin ownership and drive
  always_comb begin
    for (int p = 0; p < CIO_NPORT; p++) begin
      port_pin_in[p] = 32'h00000000;
    end
    for (int i = 0; i < CIO_NPIN; i++) begin
      // unshared pins stay with wider port
      owner[i]   = pin_owner(i, {cfg_q[4].enable, cfg_q[3].enable,
                                 cfg_q[2].enable, cfg_q[1].enable,
                                 cfg_q[0].enable}, link_q);
      pout_d[i]  = 1'b0;
      poe_b_d[i] = 1'b1;
      if (owner[i] < 3'h5) begin
        port_pin_in[owner[i]][i] = pin_s2_q[i];
        if (cfg_q[owner[i]].dir_out) begin
          if (cfg_q[owner[i]].open_drain) begin
            poe_b_d[i] = port_pin_out[owner[i]][i];
          end else begin
            pout_d[i]  = port_pin_out[owner[i]][i];
            poe_b_d[i] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pout_q  <= 32'h00000000;
      poe_b_q <= 32'hFFFFFFFF;
    end else begin
      pout_q  <= pout_d;
      poe_b_q <= poe_b_d;
    end
  end

  for (genvar p = 0; p < CIO_NPORT; p++) begin : g_port
    localparam int PW = cio_port_width(p);
    logic [PW-1:0] po;
    logic [PW-1:0] px;
    logic [PW-1:0] pc;
    // port runs at selected block rate
    // selections past the last block never tick rather than go unknown
    assign port_tick[p] = (cfg_q[p].clk_sel < 3'(CIO_NCLK)) &&
                          cb_tick[cfg_q[p].clk_sel];

    cio_port_unit #(
      .W (PW)
    ) u_unit (
      .clk_in     (clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (port_tick[p]),
      .cfg_in     (cfg_q[p]),
      .pins_in    (port_pin_in[p][PW-1:0]),
      .strobe_in  (stb_s2_q[p]),
      .pins_out   (po),
      .strobe_out (port_stb[p]),
      .wr_data_in (wr_data[p]),
      .wr_time_in (wr_time[p]),
      .wr_cond_in (wr_cond[p]),
      .rd_pop_in  (rd_pop[p]),
      .wdata_in   (wmerged),
      .xfer_out   (px),
      .cond_out   (pc),
      .stat_out   (port_stat[p]),
      .event_out  (port_evt[p])
    );

    assign port_pin_out[p] = 32'(po);
    assign port_xfer[p]    = 32'(px);
    assign port_cond[p]    = 32'(pc);
  end

  // outputs
  assign avs_waitrequest_out      = rd_acc;
  assign avs_readdata_out         = rdata_q;
  assign pin_out                  = pout_q;
  assign pin_oe_b_out             = poe_b_q;
  assign strobe_out_handshake_out = port_stb;
  assign event_out                = port_evt;
  assign irq_out                  = irq_q;

endmodule

// ---- rtl/cio_port_unit.sv ----
`timescale 1ns/1ps
module cio_port_unit
  import cio_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // timing and configuration
  input  wire logic         tick_in,
  input  wire cio_cfg_type  cfg_in,
  // pin side
  input  wire logic [W-1:0] pins_in,
  input  wire logic         strobe_in,
  output logic      [W-1:0] pins_out,
  output logic              strobe_out,
  // software side
  input  wire logic         wr_data_in,
  input  wire logic         wr_time_in,
  input  wire logic         wr_cond_in,
  input  wire logic         rd_pop_in,
  input  wire logic [31:0]  wdata_in,
  output logic      [W-1:0] xfer_out,
  output logic      [W-1:0] cond_out,
  output cio_stat_type      stat_out,
  output logic              event_out
);

  logic [15:0]  cnt_q,  cnt_d;
  logic [15:0]  time_q, time_d;
  logic [15:0]  ts_q,   ts_d;
  logic [W-1:0] ser_q,  ser_d;
  logic [W-1:0] xfer_q, xfer_d;
  logic [W-1:0] cond_q, cond_d;
  cio_xfer_type st_q,   st_d;
  logic         strb_q, strb_d;
  logic         evt_q,  evt_d;
  logic         go;
  logic         cond_ok;

  // next-state of counter, serdes and transfer register
  always_comb begin
    cnt_d  = cnt_q;
    time_d = time_q;
    ts_d   = ts_q;
    ser_d  = ser_q;
    xfer_d = xfer_q;
    cond_d = cond_q;
    st_d   = st_q;
    strb_d = strb_q;
    evt_d  = 1'b0;
    if (tick_in) begin
      cnt_d = cnt_q + 16'h0001;
    end
    go = tick_in && cfg_in.enable &&
         (!cfg_in.time_wait || cnt_q == time_q) &&
         (!cfg_in.strb_in || strobe_in);
    case (cfg_in.cond)
      CIO_COND_NONE: cond_ok = 1'b1;
      CIO_COND_EQ:   cond_ok = (pins_in == cond_q);
      CIO_COND_NE:   cond_ok = (pins_in != cond_q);
      default:       cond_ok = 1'b0;
    endcase
    if (wr_time_in) begin
      time_d = wdata_in[15:0];
    end
    if (wr_cond_in) begin
      cond_d = wdata_in[W-1:0];
    end
    if (tick_in) begin
      strb_d = 1'b0; // outgoing strobe lasts one port tick
    end
    if (cfg_in.dir_out) begin
      if (st_q == CIO_FULL && go) begin
        ser_d  = xfer_q;
        st_d   = CIO_EMPTY;
        ts_d   = cnt_q;
        strb_d = cfg_in.strb_out;
      end
      if (wr_data_in) begin
        xfer_d = wdata_in[W-1:0];
        st_d   = CIO_FULL;
      end
    end else begin
      ser_d = pins_in;
      if (rd_pop_in) begin
        st_d = CIO_EMPTY;
      end
      // capture after the pop so a fresh word is never lost
      if (go && cond_ok) begin
        xfer_d = pins_in;
        st_d   = CIO_FULL;
        ts_d   = cnt_q;
        evt_d  = 1'b1;
      end
    end
  end

  // register stage
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_q  <= CIO_CNT_RST;
      time_q <= CIO_CNT_RST;
      ts_q   <= CIO_CNT_RST;
      ser_q  <= '0;
      xfer_q <= '0;
      cond_q <= '0;
      st_q   <= CIO_EMPTY;
      strb_q <= 1'b0;
      evt_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      time_q <= time_d;
      ts_q   <= ts_d;
      ser_q  <= ser_d;
      xfer_q <= xfer_d;
      cond_q <= cond_d;
      st_q   <= st_d;
      strb_q <= strb_d;
      evt_q  <= evt_d;
    end
  end

  // outputs straight from flops
  assign pins_out   = ser_q;
  assign strobe_out = strb_q;
  assign xfer_out   = xfer_q;
  assign cond_out   = cond_q;
  assign event_out  = evt_q;
  assign stat_out   = '{full: st_q == CIO_FULL, count: cnt_q, tstamp: ts_q};

endmodule

// ---- tb/cio_pin_model.sv ----
`timescale 1ns/1ps
// far-side hardware on the pins: pull-downs plus an optional driver
module cio_pin_model (
  // port side
  input  wire logic [31:0] pin_out_in,
  input  wire logic [31:0] pin_oe_b_in,
  // scenario control
  input  wire logic [31:0] ext_val_in,
  input  wire logic [31:0] ext_en_in,
  input  wire logic [4:0]  strb_req_in,
  // levels seen by the ports
  output logic      [31:0] pin_level_out,
  output logic      [4:0]  strobe_out
);
  // released pin level
  // a released pin with no far driver sinks to its pull-down
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pin_oe_b_in[i])
        pin_level_out[i] = pin_out_in[i];
      else if (ext_en_in[i])
        pin_level_out[i] = ext_val_in[i];
      else
        pin_level_out[i] = 1'h0;
    end
  end
  // ready strobe
  // raised only when a scenario asks for it
  assign strobe_out = strb_req_in;
endmodule

// ---- tb/cio_port_props.sv ----
`timescale 1ns/1ps
// bus and pin checks on the port top, seen from its ports only
module cio_port_props (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // register bus
  input wire logic [11:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // pins, strobes, events
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_b_out,
  input wire logic [4:0]  strobe_in_handshake_in,
  input wire logic [4:0]  strobe_out_handshake_out,
  input wire logic [4:0]  event_out,
  input wire logic        irq_out
);
  logic       we;
  logic       stab;
  logic       link_q;
  logic       link_d;
  logic [4:0] mask_q;
  logic [4:0] mask_d;
  logic [5:0] c4_q;
  logic [5:0] c4_d;
  logic [2:0] m4_q;
  logic [2:0] m4_d;
  // shadow of link, mask and port 4 mode; pins lag a mode change two edges
  always_comb begin
    we = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    link_d = link_q;
    mask_d = mask_q;
    m4_d = m4_q;
    c4_d = {c4_q[2:0], m4_q};
    stab = (m4_q == c4_q[2:0]) && (m4_q == c4_q[5:3]);
    if (we && avs_address_in == 12'h100) link_d = avs_writedata_in[0];
    if (we && avs_address_in == 12'h184) mask_d = avs_writedata_in[4:0];
    if (we && avs_address_in == 12'h080) m4_d = avs_writedata_in[2:0];
  end
  // register the shadows
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      link_q <= 1'h0;
      mask_q <= 5'h00;
      m4_q   <= 3'h0;
      c4_q   <= 6'h00;
    end else begin
      link_q <= link_d;
      mask_q <= mask_d;
      m4_q   <= m4_d;
      c4_q   <= c4_d;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_read_one_wait: assert property (
    $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read wait not one cycle");
  chk_write_no_wait: assert property (
    avs_write_in |-> !avs_waitrequest_out)
    else $error("write stalled");
  chk_rdata_hold: assert property (
    !avs_read_in |-> $stable(avs_readdata_out))
    else $error("read data moved without a read");
  chk_link_pins_off: assert property (
    link_q && $past(link_q) && $past(link_q, 2) |-> &pin_oe_b_out[7:4])
    else $error("link pins still driven");
  chk_irq_follows: assert property (
    |(event_out & mask_q) |-> ##[0:3] irq_out)
    else $error("unmasked event gave no interrupt");
  chk_irq_masked: assert property (
    mask_q == 5'h00 && $past(mask_q) == 5'h00 |-> !irq_out)
    else $error("interrupt with all masked");
  chk_port_dir_same: assert property (
    stab && !m4_q[2] |-> pin_oe_b_out[31:16] == {16{pin_oe_b_out[16]}})
    else $error("mixed direction on wide port");
  chk_od_low_only: assert property (
    stab && m4_q == 3'h7 |-> pin_out[31:16] == 16'h0000)
    else $error("open drain drove high");
endmodule

bind cio_port_top cio_port_props chk_inst (
  .clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .pin_in, .pin_out, .pin_oe_b_out,
  .strobe_in_handshake_in, .strobe_out_handshake_out, .event_out, .irq_out
);

// ---- tb/test_cio_port_top.sv ----
`timescale 1ns/1ps
// bench for the port top: bus tasks, pin model and self checks
module test_cio_port_top;
  logic        clk_in = 1'h0;
  logic        rst_b_in = 1'h0;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic        wreq;
  logic        irq;
  logic        seen;
  logic [11:0] adr = 12'h000;
  logic [4:0]  strb_req = 5'h00;
  logic [4:0]  strb_o;
  logic [4:0]  strb_i;
  logic [4:0]  evt;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] pin_o;
  logic [31:0] pin_oe_b;
  logic [31:0] pin_lvl;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] t0;
  logic [31:0] t1;
  int          err_count = 0;
  int          num_checks = 0;
  // 100 ns clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  cio_port_top dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .pin_in(pin_lvl), .pin_out(pin_o),
    .pin_oe_b_out(pin_oe_b), .strobe_in_handshake_in(strb_i),
    .strobe_out_handshake_out(strb_o), .event_out(evt), .irq_out(irq));
  cio_pin_model far (
    .pin_out_in(pin_o), .pin_oe_b_in(pin_oe_b), .ext_val_in(ext_val),
    .ext_en_in(ext_en), .strb_req_in(strb_req), .pin_level_out(pin_lvl),
    .strobe_out(strb_i));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one bus cycle; request held until the edge that samples waitrequest low
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    do @(posedge clk_in); while (wreq !== 1'h0);
    q = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  task automatic wrt(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask
  // new far-side level, then time for the two-flop synchroniser
  task automatic pins(input logic [31:0] v);
    ext_val <= v;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // the whole run is a few hundred cycles
  initial begin
    #1000000;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'h1;
    rdc(12'h000, 32'h0);
    rdc(12'h1F0, 32'h0);
    wrt(12'h140, 32'h5);
    rdc(12'h140, 32'h0);
    // counter on the reference block: reads are three cycles apart
    xfer(1'h0, 12'h008, 32'h0, t0);
    xfer(1'h0, 12'h008, 32'h0, t1);
    chk(t1 - t0, 32'h3);
    // block 1 divides by four: twelve cycles give three ticks
    wrt(12'h144, 32'h3);
    wrt(12'h060, 32'h100);
    xfer(1'h0, 12'h068, 32'h0, t0);
    repeat (4) xfer(1'h0, 12'h068, 32'h0, t1);
    chk(t1 - t0, 32'h3);
    // 4-bit output with outgoing strobe and timestamp
    xfer(1'h0, 12'h028, 32'h0, t0);
    wrt(12'h020, 32'h83);
    wrt(12'h024, 32'hA);
    seen = 1'h0;
    repeat (6) begin
      @(negedge clk_in);
      seen = seen | strb_o[1];
    end
    chk(seen, 32'h1);
    chk({pin_oe_b[3:0], pin_o[3:0]}, 32'h0A);
    xfer(1'h0, 12'h02C, 32'h0, t1);
    chk(t1 - t0, 32'h6);
    // a programmed future count holds the next output back
    xfer(1'h0, 12'h028, 32'h0, t0);
    wrt(12'h020, 32'h0B);
    wrt(12'h028, t0 + 32'h20);
    wrt(12'h024, 32'hA);
    rdc(12'h034, 32'h1);
    repeat (40) @(posedge clk_in);
    rdc(12'h02C, t0 + 32'h20);
    // 1-bit port takes pin 0 only
    wrt(12'h000, 32'h3);
    wrt(12'h004, 32'h1);
    repeat (4) @(posedge clk_in);
    chk(pin_o[3:0], 32'hB);
    chk(pin_oe_b, 32'hFFFFFFF0);
    wrt(12'h020, 32'h7);
    wrt(12'h024, 32'h5);
    repeat (4) @(posedge clk_in);
    chk({pin_o[3:1], pin_oe_b[3:1]}, 32'h2);
    wrt(12'h000, 32'h0);
    wrt(12'h020, 32'h0);
    // wide port under the link
    wrt(12'h080, 32'h3);
    wrt(12'h084, 32'hFFFFFFFF);
    wrt(12'h100, 32'h1);
    repeat (4) @(posedge clk_in);
    chk(pin_oe_b, 32'h000000F0);
    chk(pin_o[31:8], 32'hFFFFFF);
    wrt(12'h080, 32'h7);
    wrt(12'h100, 32'h0);
    repeat (4) @(posedge clk_in);
    chk(pin_oe_b, 32'hFFFFFFFF);
    wrt(12'h080, 32'h0);
    // 8-bit input: masked event, then unmasked interrupt
    ext_en <= 32'hFF;
    wrt(12'h040, 32'h1);
    pins(32'h5A);
    chk(irq, 32'h0);
    rdc(12'h180, 32'h4);
    wrt(12'h184, 32'h4);
    repeat (3) @(posedge clk_in);
    chk(irq, 32'h1);
    // capture now waits for the strobe and for pins equal to 0x33
    wrt(12'h040, 32'h51);
    wrt(12'h050, 32'h33);
    rdc(12'h044, 32'h5A);
    pins(32'h33);
    rdc(12'h054, 32'h0);
    strb_req <= 5'h04;
    pins(32'h5A);
    rdc(12'h054, 32'h0);
    chk(evt, 32'h00);
    pins(32'h33);
    chk(evt, 32'h04);
    rdc(12'h054, 32'h1);
    rdc(12'h044, 32'h33);
    wrt(12'h040, 32'h0);
    wrt(12'h180, 32'h4);
    repeat (3) @(posedge clk_in);
    chk(irq, 32'h0);
    // block 1 fed by rising edges on pin 0, no division
    wrt(12'h144, 32'h10000);
    pins(32'h0);
    xfer(1'h0, 12'h068, 32'h0, t0);
    pins(32'h1);
    pins(32'h0);
    pins(32'h1);
    xfer(1'h0, 12'h068, 32'h0, t1);
    chk(t1 - t0, 32'h2);
    wrap_up();
  end
endmodule
